// file: core/qba_top.sv
`timescale 1ns/1ps
module qba_top
    import qba_pkg::*;
(
    input  wire logic               pclk,                  // Bus clock, 50 MHz
    input  wire logic               presetn,               // Async reset, active low
    input  wire logic               psel,                  // APB select
    input  wire logic               penable,               // APB access phase
    input  wire logic               pwrite,                // APB write
    input  wire logic [11:0]        paddr,                 // APB byte address
    input  wire logic [31:0]        pwdata,                // APB write data
    output logic [31:0]             prdata,                // APB read data
    output logic                    pready,                // APB ready
    output logic                    pslverr,               // APB error
    input  wire logic [NUM_CPU-1:0] bus_request_n,         // Bus requests, active low
    output logic [NUM_CPU-1:0]      bus_grant_n,           // Bus grants, active low
    input  wire logic               transfer_start_n,      // Address tenure start
    input  wire logic [NUM_CPU-1:0] transaction_done,      // Buffer released, per CPU
    input  wire logic [NUM_CPU-1:0] error_detect,          // Machine-check error, per CPU
    input  wire logic               transfer_ack_line_i,   // Transfer-ack pin level
    output logic                    transfer_ack_line_o,   // Transfer-ack pin drive
    output logic                    transfer_ack_line_oe,  // Transfer-ack pin enable
    output logic                    cpu2_hard_reset_n,     // CPU2 hard reset
    output logic                    cpu3_hard_reset_n,     // CPU3 hard reset
    output logic                    cpu2_soft_reset_n,     // CPU2 soft reset
    output logic                    cpu3_soft_reset_n,     // CPU3 soft reset
    output logic                    cpu0_machine_check_n,  // CPU0 machine check
    output logic                    cpu1_machine_check_n,  // CPU1 machine check
    output logic                    cpu2_machine_check_n,  // CPU2 machine check
    output logic                    cpu3_machine_check_n   // CPU3 machine check
);

    function automatic logic is_mapped(input logic [11:0] a);
        if (a == ARB_CTL_OFF)
            return 1'b1;
        else if (a == HARD_RST_OFF)
            return 1'b1;
        else if (a == SOFT_RST_OFF)
            return 1'b1;
        else if (a == PROC_ID_OFF)
            return 1'b1;
        else if (a == ERR_STAT_OFF)
            return 1'b1;
        else if (a == BUF_STAT_OFF)
            return 1'b1;
        else
            return 1'b0;
    endfunction

    qba_state_t         st;
    qba_state_t         next_st;
    logic [NUM_CPU-1:0] arb_enable;
    logic [NUM_CPU-1:0] can_issue;
    logic [ID_W-1:0]    owner;
    logic               wr_en;
    logic               setup;
    logic [BUF_W-1:0]   sum;
    logic [PEND_W-1:0]  p;
    logic               err_clr0;
    logic               err_clr1;
    logic               mc_clr_a;
    logic               mc_clr_b;

    assign arb_enable = st.quad_mode ? QUAD_MASK : DUAL_MASK;

    // A processor may start a new transaction only with a free buffer
    generate
        for (genvar g = 0; g < NUM_CPU; g++)
        begin : g_issue
            assign can_issue[g] = (st.pend[g] < MAX_PIPE_PER_CPU)
                                  && (st.bufs < MAX_BUFFERS);
        end
    endgenerate

    qba_arbiter u_arbiter (
        .pclk      (pclk),
        .presetn   (presetn),
        .req       (~bus_request_n),
        .enable    (arb_enable),
        .can_issue (can_issue),
        .grant_n   (bus_grant_n),
        .owner     (owner)
    );

    always_comb
    begin
        next_st  = st;
        sum      = '0;
        p        = '0;
        setup    = psel && !penable;
        wr_en    = psel && penable && st.pready && pwrite;
        err_clr0 = 1'b0;
        err_clr1 = 1'b0;
        mc_clr_a = 1'b0;
        mc_clr_b = 1'b0;

        // Register writes take effect at the completing access edge
        next_st.pready  = setup;
        next_st.pslverr = setup && !is_mapped(paddr);
        if (wr_en)
        begin
            if (paddr == ARB_CTL_OFF)
            begin
                next_st.quad_mode  = pwdata[ARB_QUAD_BIT];
                next_st.ta_hold_en = pwdata[ARB_TA_HOLD_BIT];
            end
            else if (paddr == HARD_RST_OFF)
            begin
                next_st.hard_ctl = pwdata[RST_CPU3_BIT:RST_CPU2_BIT];
            end
            else if (paddr == SOFT_RST_OFF)
            begin
                next_st.soft_ctl = pwdata[RST_CPU3_BIT:RST_CPU2_BIT];
            end
            else if (paddr == ERR_STAT_OFF)
            begin
                err_clr0 = pwdata[ERR_CPU0_BIT];
                err_clr1 = pwdata[ERR_CPU1_BIT];
                mc_clr_a = pwdata[MC_SRC_A_BIT];
                mc_clr_b = pwdata[MC_SRC_B_BIT];
            end
        end

        // Read data is prepared in the setup cycle
        next_st.prdata = '0;
        if (setup && !pwrite)
        begin
            if (paddr == ARB_CTL_OFF)
            begin
                next_st.prdata[ARB_QUAD_BIT]    = st.quad_mode;
                next_st.prdata[ARB_TA_HOLD_BIT] = st.ta_hold_en;
            end
            else if (paddr == HARD_RST_OFF)
            begin
                next_st.prdata[RST_CPU3_BIT:RST_CPU2_BIT] = st.hard_ctl;
            end
            else if (paddr == SOFT_RST_OFF)
            begin
                next_st.prdata[RST_CPU3_BIT:RST_CPU2_BIT] = st.soft_ctl;
            end
            else if (paddr == PROC_ID_OFF)
            begin
                next_st.prdata[PROC_ID_LSB +: 8] = 8'(owner);
            end
            else if (paddr == ERR_STAT_OFF)
            begin
                next_st.prdata[ERR_CPU1_BIT:ERR_CPU0_BIT] = st.err_sticky;
                next_st.prdata[MC_SRC_A_BIT] = !st.mc_src_n[0];
                next_st.prdata[MC_SRC_B_BIT] = !st.mc_src_n[1];
            end
            else if (paddr == BUF_STAT_OFF)
            begin
                next_st.prdata[BUF_W-1:0] = st.bufs;
            end
        end

        // Error capture; a new error wins over a clear in the same cycle
        next_st.err_sticky[0] = error_detect[0]
                                || (st.err_sticky[0] && !err_clr0);
        next_st.err_sticky[1] = error_detect[1]
                                || (st.err_sticky[1] && !err_clr1);
        next_st.mc_src_n[0] = !(error_detect[0] || error_detect[2]
                                || (!st.mc_src_n[0] && !mc_clr_a));
        next_st.mc_src_n[1] = !(error_detect[1] || error_detect[3]
                                || (!st.mc_src_n[1] && !mc_clr_b));

        // Extra processors leave reset only in four-processor mode
        next_st.hreset_n = next_st.quad_mode ? ~next_st.hard_ctl : 2'h0;
        next_st.sreset_n = next_st.quad_mode ? ~next_st.soft_ctl : 2'h0;

        // Outstanding transactions per processor and buffers in use
        for (int i = 0; i < NUM_CPU; i++)
        begin
            p = st.pend[i];
            if (!transfer_start_n && owner == ID_W'(i) && !bus_grant_n[i]
                && p < MAX_PIPE_PER_CPU)
            begin
                p = p + 2'h1;
            end
            if (transaction_done[i] && p != '0)
            begin
                p = p - 2'h1;
            end
            next_st.pend[i] = p;
            sum = sum + BUF_W'(p);
        end
        next_st.bufs = sum;

        // Transfer-ack keeper: precharge until confirmed high, then hold
        next_st.ta_o = 1'b1;
        case (st.ta_state)
            QBA_TA_OFF:
            begin
                next_st.ta_oe   = 1'b0;
                next_st.pre_cnt = '0;
                if (st.ta_hold_en && st.bufs == '0)
                begin
                    next_st.ta_state = QBA_TA_PRECHARGE;
                    next_st.ta_oe    = 1'b1;
                end
            end
            QBA_TA_PRECHARGE:
            begin
                next_st.ta_oe = 1'b1;
                if (!st.ta_hold_en)
                begin
                    next_st.ta_state = QBA_TA_OFF;
                    next_st.ta_oe    = 1'b0;
                end
                else if (st.pre_cnt >= TA_PRE_LAST && transfer_ack_line_i)
                begin
                    next_st.ta_state = QBA_TA_HOLD;
                end
                else if (st.pre_cnt < TA_PRE_LAST)
                begin
                    next_st.pre_cnt = st.pre_cnt + 4'h1;
                end
            end
            QBA_TA_HOLD:
            begin
                next_st.ta_oe = 1'b1;
                // Let the bus target drive acknowledge during data tenures
                if (!st.ta_hold_en || st.bufs != '0)
                begin
                    next_st.ta_state = QBA_TA_OFF;
                    next_st.ta_oe    = 1'b0;
                end
            end
            default:
            begin
                next_st.ta_state = QBA_TA_OFF;
                next_st.ta_oe    = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st            <= '0;
            st.quad_mode  <= QUAD_RESET;
            st.ta_hold_en <= TA_HOLD_RESET;
            st.hard_ctl   <= RST_CTL_RESET;
            st.soft_ctl   <= RST_CTL_RESET;
            st.hreset_n   <= 2'h0;
            st.sreset_n   <= 2'h0;
            st.mc_src_n   <= 2'h3;
            st.ta_state   <= QBA_TA_OFF;
            st.ta_o       <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign prdata               = st.prdata;
    assign pready               = st.pready;
    assign pslverr              = st.pslverr;
    assign transfer_ack_line_o  = st.ta_o;
    assign transfer_ack_line_oe = st.ta_oe;
    assign cpu2_hard_reset_n    = st.hreset_n[0];
    assign cpu3_hard_reset_n    = st.hreset_n[1];
    assign cpu2_soft_reset_n    = st.sreset_n[0];
    assign cpu3_soft_reset_n    = st.sreset_n[1];
    assign cpu0_machine_check_n = st.mc_src_n[0];
    assign cpu2_machine_check_n = st.mc_src_n[0];
    assign cpu1_machine_check_n = st.mc_src_n[1];
    assign cpu3_machine_check_n = st.mc_src_n[1];

endmodule // qba_top

// file: core/qba_pkg.sv
package qba_pkg;

    localparam int NUM_CPU         = 4;
    localparam int ID_W            = 2;
    localparam int PEND_W          = 2;
    localparam int BUF_W           = 3;

    // Pipelining limits
    localparam logic [PEND_W-1:0] MAX_PIPE_PER_CPU = 2'h2;
    localparam logic [BUF_W-1:0]  MAX_BUFFERS      = 3'h6;
    localparam int                BUFFER_BYTES     = 64;

    // Arbitration modes: enabled requesters
    localparam logic [NUM_CPU-1:0] DUAL_MASK = 4'h3;
    localparam logic [NUM_CPU-1:0] QUAD_MASK = 4'hF;

    // Register byte offsets
    localparam logic [11:0] ARB_CTL_OFF  = 12'h000;
    localparam logic [11:0] HARD_RST_OFF = 12'h004;
    localparam logic [11:0] SOFT_RST_OFF = 12'h008;
    localparam logic [11:0] PROC_ID_OFF  = 12'h00C;
    localparam logic [11:0] ERR_STAT_OFF = 12'h010;
    localparam logic [11:0] BUF_STAT_OFF = 12'h014;

    // Field positions
    localparam int ARB_QUAD_BIT    = 17;
    localparam int ARB_TA_HOLD_BIT = 18;
    localparam int RST_CPU2_BIT    = 4;
    localparam int RST_CPU3_BIT    = 5;
    localparam int PROC_ID_LSB     = 24;
    localparam int ERR_CPU0_BIT    = 0;
    localparam int ERR_CPU1_BIT    = 1;
    localparam int MC_SRC_A_BIT    = 8;
    localparam int MC_SRC_B_BIT    = 9;

    // Reset values
    localparam logic       QUAD_RESET    = 1'b0;
    localparam logic       TA_HOLD_RESET = 1'b0;
    localparam logic [1:0] RST_CTL_RESET = 2'h0;

    // Transfer-acknowledge precharge time
    localparam int CLK_PERIOD_NS     = 20;
    localparam int TA_PRECHARGE_NS   = 40;
    localparam int TA_PRE_CYC_RAW    = (TA_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TA_PRE_CYC        = (TA_PRE_CYC_RAW < 1) ? 1 : TA_PRE_CYC_RAW;
    localparam int PRE_W             = 4;
    localparam logic [PRE_W-1:0] TA_PRE_LAST = PRE_W'(TA_PRE_CYC - 1);

    typedef enum logic [1:0] {
        QBA_TA_OFF,
        QBA_TA_PRECHARGE,
        QBA_TA_HOLD
    } qba_ta_state_t;

    typedef struct packed {
        logic [NUM_CPU-1:0] grant_n;
        logic [ID_W-1:0]    owner;
        logic               busy;
    } qba_arb_state_t;

    typedef struct packed {
        logic [31:0]                    prdata;
        logic                           pready;
        logic                           pslverr;
        logic                           quad_mode;
        logic                           ta_hold_en;
        logic [1:0]                     hard_ctl;
        logic [1:0]                     soft_ctl;
        logic [1:0]                     hreset_n;
        logic [1:0]                     sreset_n;
        logic [1:0]                     err_sticky;
        logic [1:0]                     mc_src_n;
        logic [NUM_CPU-1:0][PEND_W-1:0] pend;
        logic [BUF_W-1:0]               bufs;
        qba_ta_state_t                  ta_state;
        logic [PRE_W-1:0]               pre_cnt;
        logic                           ta_o;
        logic                           ta_oe;
    } qba_state_t;

endpackage

// file: core/qba_arbiter.sv
`timescale 1ns/1ps
module qba_arbiter
    import qba_pkg::*;
(
    input  wire logic               pclk,       // Bus clock
    input  wire logic               presetn,    // Async reset, active low
    input  wire logic [NUM_CPU-1:0] req,        // Active-high requests
    input  wire logic [NUM_CPU-1:0] enable,     // Requesters allowed by mode
    input  wire logic [NUM_CPU-1:0] can_issue,  // Requester is under its pipeline limit and a buffer is free
    output logic [NUM_CPU-1:0]      grant_n,    // Bus grants, active low
    output logic [ID_W-1:0]         owner       // Current or last grant owner
);

    qba_arb_state_t st;
    qba_arb_state_t next_st;
    logic [NUM_CPU-1:0] elig;
    logic [ID_W-1:0]    idx;
    logic               found;

    always_comb
    begin
        next_st = st;
        elig    = req & enable & can_issue;
        found   = 1'b0;
        idx     = st.owner;
        // Keep the grant while the owner still asks and may issue
        if (st.busy && elig[st.owner])
        begin
            next_st.grant_n = ~(NUM_CPU'(1) << st.owner);
        end
        else
        begin
            // Round robin, starting after the last owner
            for (int k = 1; k <= NUM_CPU; k++)
            begin
                idx = ID_W'(int'(st.owner) + k);
                if (!found && elig[idx])
                begin
                    found          = 1'b1;
                    next_st.owner  = idx;
                end
            end
            next_st.busy    = found;
            next_st.grant_n = found ? ~(NUM_CPU'(1) << next_st.owner) : '1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '{grant_n: '1, owner: '0, busy: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign grant_n = st.grant_n;
    assign owner   = st.owner;

endmodule // qba_arbiter

// file: test/qba_monitor.sv
`timescale 1ns/1ps
module qba_monitor
    import qba_pkg::*;
(
    input wire logic               pclk,                 // Clock
    input wire logic               presetn,              // Reset
    input wire logic               psel,                 // Select
    input wire logic               penable,              // Access
    input wire logic               pwrite,               // Write
    input wire logic [11:0]        paddr,                // Address
    input wire logic [31:0]        pwdata,               // Write data
    input wire logic               pready,               // Ready
    input wire logic [NUM_CPU-1:0] bus_request_n,        // Requests
    input wire logic [NUM_CPU-1:0] bus_grant_n,          // Grants
    input wire logic [NUM_CPU-1:0] error_detect,         // Errors
    input wire logic               transfer_ack_line_o,  // Ack drive
    input wire logic               transfer_ack_line_oe, // Ack enable
    input wire logic               cpu2_hard_reset_n,    // Hard reset 2
    input wire logic               cpu3_hard_reset_n,    // Hard reset 3
    input wire logic               cpu2_soft_reset_n,    // Soft reset 2
    input wire logic               cpu3_soft_reset_n,    // Soft reset 3
    input wire logic               cpu0_machine_check_n, // Check 0
    input wire logic               cpu1_machine_check_n, // Check 1
    input wire logic               cpu2_machine_check_n, // Check 2
    input wire logic               cpu3_machine_check_n  // Check 3
);
    logic       quad_q;
    logic       ta_q;
    logic [1:0] hard_q;
    logic [1:0] soft_q;
    wire        wr = psel && penable && pready && pwrite;

    // Shadow of the control bits as written over the bus
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            quad_q <= 1'b0;
            ta_q   <= 1'b0;
            hard_q <= 2'h0;
            soft_q <= 2'h0;
        end
        else if (wr)
        begin
            if (paddr == ARB_CTL_OFF)
            begin
                quad_q <= pwdata[ARB_QUAD_BIT];
                ta_q   <= pwdata[ARB_TA_HOLD_BIT];
            end
            if (paddr == HARD_RST_OFF) hard_q <= pwdata[5:4];
            if (paddr == SOFT_RST_OFF) soft_q <= pwdata[5:4];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence

    a_apb_answer: assert property (s_setup |=> s_access)
        else $error("no ready after setup");
    a_grant_single: assert property ($onehot0(~bus_grant_n))
        else $error("more than one grant");
    a_grant_cause: assert property ((bus_grant_n != 4'hF) |->
        ((~bus_grant_n & ~$past(bus_request_n)) != 4'h0)) else $error("grant without request");
    a_dual_only: assert property ((!quad_q && !$past(quad_q)) |->
        (bus_grant_n[3:2] == 2'h3)) else $error("grant to cpu 2 or 3 in dual mode");
    a_hard_ctl: assert property (($stable(quad_q) && $stable(hard_q)) |->
        (cpu2_hard_reset_n == (quad_q && !hard_q[0])) &&
        (cpu3_hard_reset_n == (quad_q && !hard_q[1]))) else $error("hard reset level wrong");
    a_soft_ctl: assert property (($stable(quad_q) && $stable(soft_q)) |->
        (cpu2_soft_reset_n == (quad_q && !soft_q[0])) &&
        (cpu3_soft_reset_n == (quad_q && !soft_q[1]))) else $error("soft reset level wrong");
    a_mc_shared: assert property ((cpu0_machine_check_n == cpu2_machine_check_n) &&
        (cpu1_machine_check_n == cpu3_machine_check_n)) else $error("machine check pair split");
    a_mc_raise: assert property ((error_detect[0] || error_detect[2]) |->
        ##[1:2] !cpu0_machine_check_n) else $error("machine check not raised");
    a_ta_cause: assert property ($rose(transfer_ack_line_oe) |-> ta_q)
        else $error("ack keeper enabled while off");
    a_ta_level: assert property (transfer_ack_line_oe |-> transfer_ack_line_o)
        else $error("ack keeper drives low");
    a_ta_drop: assert property ((!ta_q && !$past(ta_q)) |-> !transfer_ack_line_oe)
        else $error("ack keeper stays on");
endmodule // qba_monitor

bind qba_top qba_monitor qba_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .bus_request_n(bus_request_n), .bus_grant_n(bus_grant_n), .error_detect(error_detect),
    .transfer_ack_line_o(transfer_ack_line_o), .transfer_ack_line_oe(transfer_ack_line_oe),
    .cpu2_hard_reset_n(cpu2_hard_reset_n), .cpu3_hard_reset_n(cpu3_hard_reset_n),
    .cpu2_soft_reset_n(cpu2_soft_reset_n), .cpu3_soft_reset_n(cpu3_soft_reset_n),
    .cpu0_machine_check_n(cpu0_machine_check_n), .cpu1_machine_check_n(cpu1_machine_check_n),
    .cpu2_machine_check_n(cpu2_machine_check_n), .cpu3_machine_check_n(cpu3_machine_check_n));

// file: test/qba_cpu_model.sv
`timescale 1ns/1ps
module qba_cpu_model
    import qba_pkg::*;
(
    input  wire logic               pclk,             // Clock
    input  wire logic               presetn,          // Reset
    input  wire logic [NUM_CPU-1:0] want,             // Processors wanting the bus
    input  wire logic [NUM_CPU-1:0] bus_grant_n,      // Grants
    input  wire logic               ta_o,             // Ack drive
    input  wire logic               ta_oe,            // Ack enable
    output logic [NUM_CPU-1:0]      bus_request_n,    // Requests
    output logic                    transfer_start_n, // Address tenure start
    output logic                    ta_line           // Ack wire level
);
    assign bus_request_n = ~want;
    // Ack wire carries a pull-up when nobody drives it
    assign ta_line = ta_oe ? ta_o : 1'b1;

    // Granted processor starts a tenure every other cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            transfer_start_n <= 1'b1;
        else
            transfer_start_n <= !(transfer_start_n && ((~bus_grant_n & want) != 4'h0));
    end
endmodule // qba_cpu_model

// file: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import qba_pkg::*;
    logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata, rd;
    logic [NUM_CPU-1:0] want, req_n, grant_n, done, err_det, gseen;
    logic               start_n, ta_o, ta_oe, ta_line, h2, h3, s2, s3, m0, m1, m2, m3;
    int                 err_total, tests_run;

    qba_top qba_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_request_n(req_n), .bus_grant_n(grant_n),
        .transfer_start_n(start_n), .transaction_done(done), .error_detect(err_det),
        .transfer_ack_line_i(ta_line), .transfer_ack_line_o(ta_o), .transfer_ack_line_oe(ta_oe),
        .cpu2_hard_reset_n(h2), .cpu3_hard_reset_n(h3), .cpu2_soft_reset_n(s2),
        .cpu3_soft_reset_n(s3), .cpu0_machine_check_n(m0), .cpu1_machine_check_n(m1),
        .cpu2_machine_check_n(m2), .cpu3_machine_check_n(m3));
    qba_cpu_model qba_cpu_model_inst (.pclk(pclk), .presetn(presetn), .want(want),
        .bus_grant_n(grant_n), .ta_o(ta_o), .ta_oe(ta_oe), .bus_request_n(req_n),
        .transfer_start_n(start_n), .ta_line(ta_line));

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // Grants seen while processors ask; cleared whenever nobody asks
    always @(posedge pclk) gseen <= (want == 4'h0) ? 4'h0 : (gseen | ~grant_n);

    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Ready and data are taken at the rising edge; the watchdog ends a hang
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task done_pulse(input logic [3:0] v);
        @(posedge pclk) done <= v;
        @(posedge pclk) done <= 4'h0;
    endtask
    task final_report;
        $display("tests_run=%0d err_total=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #400000;
        err_total++;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
        final_report();
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, want, done, err_det} = '0;
        err_total = 0; tests_run = 0; presetn = 1'b0;
        tick(5);
        presetn <= 1'b1;
        tick(1);
        check({28'h0, h3, h2, s3, s2}, 32'h0);
        check({28'h0, m3, m2, m1, m0}, 32'hF);
        apb(0, ARB_CTL_OFF, 0); check(rd, 32'h0);
        $display("test reset finished");
        @(posedge pclk) want <= 4'hF;
        tick(30);
        check({28'h0, gseen}, 32'h3);
        apb(0, BUF_STAT_OFF, 0); check(rd, 32'h4);
        @(posedge pclk) want <= 4'h0;
        tick(3); done_pulse(4'h3); done_pulse(4'h3);
        apb(0, BUF_STAT_OFF, 0); check(rd, 32'h0);
        $display("test dual mode finished");
        apb(1, ARB_CTL_OFF, 32'h0002_0000);
        tick(2);
        check({28'h0, h3, h2, s3, s2}, 32'hF);
        @(posedge pclk) want <= 4'hF;
        tick(40);
        apb(0, BUF_STAT_OFF, 0); check(rd, 32'h6);
        @(posedge pclk) want <= 4'h0;
        presetn <= 1'b0;
        tick(2);
        presetn <= 1'b1;
        tick(1);
        check({28'h0, h3, h2, s3, s2}, 32'h0);
        apb(0, BUF_STAT_OFF, 0); check(rd, 32'h0);
        $display("test quad limit finished");
        apb(1, ARB_CTL_OFF, 32'h0002_0000);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge pclk) want <= 4'(1 << i);
            tick(6);
            @(posedge pclk) want <= 4'h0;
            tick(3);
            apb(0, PROC_ID_OFF, 0); check({24'h0, rd[31:24]}, 32'(i));
            done_pulse(4'(1 << i)); done_pulse(4'(1 << i));
        end
        $display("test identity finished");
        for (int k = 0; k < 4; k++)
        begin
            apb(1, HARD_RST_OFF, 32'(k) << 4);
            apb(1, SOFT_RST_OFF, 32'(3 - k) << 4);
            tick(2);
            check({30'h0, h3, h2}, 32'(~k & 3));
            check({30'h0, s3, s2}, 32'(k));
        end
        apb(1, HARD_RST_OFF, 0); apb(1, SOFT_RST_OFF, 0);
        $display("test reset control finished");
        for (int i = 0; i < 4; i++)
        begin
            @(posedge pclk) err_det <= 4'(1 << i);
            @(posedge pclk) err_det <= 4'h0;
            tick(2);
            check({28'h0, m3, m2, m1, m0}, i[0] ? 32'h5 : 32'hA);
            apb(0, ERR_STAT_OFF, 0);
            check(rd, (i < 2 ? 32'(1 << i) : 32'h0) | (i[0] ? 32'h200 : 32'h100));
            apb(1, ERR_STAT_OFF, 32'h303);
            tick(2);
            check({28'h0, m3, m2, m1, m0}, 32'hF);
        end
        $display("test machine check finished");
        apb(0, 12'h020, 0);
        check(rd, 32'h0);
        check({31'h0, serr}, 32'h1);
        apb(1, ARB_CTL_OFF, 32'h0006_0000);
        tick(8);
        check({30'h0, ta_oe, ta_line}, 32'h3);
        apb(1, ARB_CTL_OFF, 32'h0002_0000);
        tick(3);
        check({31'h0, ta_oe}, 32'h0);
        $display("test ack keeper finished");
        final_report();
    end
endmodule // tb_top
